// file: core/iwf_unit.sv
// Purpose: Crops one window from the sensor, mirrors it, substitutes test images
//          and queues the eight-bit samples for the stream channel.
// Assumes: Sensor returns sens_data_i in the cycle after sens_rd_o is high.
// Notes:   Function
// Function
// - Three format presets, all windowed; preset zero after reset.
// - Preset change refused while streaming.
// - Window rows read at full line rate, other rows skipped one per cycle.
// - Exactly one rectangular window.
// - Width 64 plus multiples of 8, height 64 plus multiples of 2.
// - Horizontal start multiple of 8, vertical start multiple of 2.
// - Window stays inside 1920x1200; full size after reset.
// - Window size and start changes refused while streaming.
// - Start values are offsets from the image origin.
// - Left-right and top-bottom mirror flags, both off after reset.
// - Format code follows encoding and sample size; mono gives 0x01080001.
// - Colour model gives Bayer blue-green, code 0x0108000B.
// - Sample size change refused while streaming.
// - Byte order selection is writable.
// - Pattern off passes sensor data; off after reset.
// - Uniform fields 0, 255, 170 and 85.
// - Ramps for both models, grey steps mono only, stripes colour only.
// - Stream data only while the stream channel is open.
// - Frame period clamps to the 0.061 Hz minimum rate; height sets maximum.
`timescale 1ns/10ps
module iwf_unit import iwf_pkg::*; #(
	parameter bit          COLOUR_MODEL  = 1'b0,
	parameter int unsigned MAX_FRAME_CYC = FRAME_MAX_CYC
) (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        stream_channel_open_i,
	input  wire logic        acq_start_i,
	input  wire logic        acq_stop_i,
	input  wire logic        cfg_wr_i,
	input  wire logic [1:0]  format_preset_select_i,
	input  wire logic [10:0] width_i,
	input  wire logic [10:0] height_i,
	input  wire logic [10:0] roi_horizontal_start_i,
	input  wire logic [10:0] roi_vertical_start_i,
	input  wire logic        mirror_left_right_i,
	input  wire logic        mirror_top_bottom_i,
	input  wire logic        sample_encoding_select_i,
	input  wire logic [1:0]  bits_per_sample_select_i,
	input  wire logic        sample_byte_order_i,
	input  wire logic [3:0]  synthetic_image_select_i,
	input  wire logic [31:0] frame_interval_i,
	input  wire logic [7:0]  sens_data_i,
	input  wire logic        out_ready_i,
	output logic             sens_rd_o,
	output logic      [10:0] sens_row_o,
	output logic      [10:0] sens_col_o,
	output logic             out_valid_o,
	output logic      [7:0]  out_data_o,
	output logic             out_sof_o,
	output logic             out_eol_o,
	output logic             streaming_o,
	output logic             cfg_reject_o,
	output logic             sample_byte_order_o,
	output logic      [1:0]  format_preset_o,
	output logic      [31:0] sample_format_code_o
);
	iwf_state_t   state;
	iwf_pattern_t pat;
	logic [1:0]   preset;
	logic [10:0]  win_w, win_h, win_hs, win_vs, r, c;
	logic         mlr, mtb, enc;
	logic [1:0]   bps;
	logic [31:0]  fcnt, ivl;
	logic         geo_ok, fmt_ok, lock_chg, accept, start, stop_now, room;
	logic         in_row, in_col, row_last, col_last;
	logic [10:0]  wx, wy, row_addr, col_addr;
	logic [2:0]   bar;
	logic [7:0]   pat_val;
	logic         q_v, q_sof, q_eol;
	logic [7:0]   q_pat;
	logic         push;
	logic [9:0]   push_data;
	logic [9:0]   head;

	assign geo_ok = width_i >= 11'(MIN_W) && width_i[2:0] == 3'h0 &&
		height_i >= 11'(MIN_H) && !height_i[0] &&
		roi_horizontal_start_i[2:0] == 3'h0 && !roi_vertical_start_i[0] &&
		{1'b0, roi_horizontal_start_i} + {1'b0, width_i} <= 12'(SENSOR_W) &&
		{1'b0, roi_vertical_start_i} + {1'b0, height_i} <= 12'(SENSOR_H);
	assign fmt_ok = sample_encoding_select_i == COLOUR_MODEL &&
		bits_per_sample_select_i == BPS_EIGHT && format_preset_select_i != 2'h3 &&
		synthetic_image_select_i <= PAT_STRIPES &&
		!(synthetic_image_select_i == PAT_STEPS && COLOUR_MODEL) &&
		!(synthetic_image_select_i == PAT_STRIPES && !COLOUR_MODEL);
	// A stream in progress freezes the geometry, preset and sample size.
	assign lock_chg = format_preset_select_i != preset || width_i != win_w ||
		height_i != win_h || roi_horizontal_start_i != win_hs ||
		roi_vertical_start_i != win_vs || bits_per_sample_select_i != bps;
	assign accept   = cfg_wr_i && geo_ok && fmt_ok && !(streaming_o && lock_chg);
	assign start    = !streaming_o && acq_start_i && stream_channel_open_i;
	assign stop_now = streaming_o && (acq_stop_i || !stream_channel_open_i);
	assign ivl      = frame_interval_i > MAX_FRAME_CYC ? MAX_FRAME_CYC : frame_interval_i;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			preset <= PRESET_ZERO;
			win_w  <= RST_W;
			win_h  <= RST_H;
			win_hs <= RST_START;
			win_vs <= RST_START;
			mlr    <= 1'b0;
			mtb    <= 1'b0;
			enc    <= COLOUR_MODEL ? ENC_BAYER : ENC_MONO;
			bps    <= BPS_EIGHT;
			pat    <= PAT_OFF;
			sample_byte_order_o <= 1'b0;
		end
		else if (accept)
		begin
			preset <= format_preset_select_i;
			win_w  <= width_i;
			win_h  <= height_i;
			win_hs <= roi_horizontal_start_i;
			win_vs <= roi_vertical_start_i;
			mlr    <= mirror_left_right_i;
			mtb    <= mirror_top_bottom_i;
			enc    <= sample_encoding_select_i;
			bps    <= bits_per_sample_select_i;
			pat    <= iwf_pattern_t'(synthetic_image_select_i);
			// Samples are one byte wide, so the order is held but moves no data.
			sample_byte_order_o <= sample_byte_order_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg_reject_o         <= 1'b0;
			format_preset_o      <= PRESET_ZERO;
			sample_format_code_o <= COLOUR_MODEL ? CODE_BAYER8 : CODE_MONO8;
		end
		else
		begin
			cfg_reject_o         <= cfg_wr_i && !accept;
			format_preset_o      <= preset;
			sample_format_code_o <= (enc == ENC_BAYER) ? CODE_BAYER8 : CODE_MONO8;
		end
	end

	// Only one window exists; all three presets read it the same way.
	assign in_row   = {1'b0, r} >= {1'b0, win_vs} && {1'b0, r} < {1'b0, win_vs} + {1'b0, win_h};
	assign in_col   = {1'b0, c} >= {1'b0, win_hs} && {1'b0, c} < {1'b0, win_hs} + {1'b0, win_w};
	assign row_last = r == 11'(SENSOR_H - 1);
	assign col_last = c == 11'(SENSOR_W - 1);
	assign wx       = c - win_hs;
	assign wy       = r - win_vs;
	assign col_addr = (mlr && in_col) ? 11'(win_hs + win_w - 11'h001 - wx) : c;
	assign row_addr = mtb ? 11'(win_vs + win_h - 11'h001 - wy) : r;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			streaming_o <= 1'b0;
		else if (start)
			streaming_o <= 1'b1;
		else if (stop_now)
			streaming_o <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || stop_now)
		begin
			state <= ST_IDLE;
			r     <= '0;
			c     <= '0;
			fcnt  <= '0;
		end
		else
		begin
			fcnt <= fcnt + 32'h1;
			case (state)
				ST_IDLE:
				begin
					fcnt <= '0;
					if (start)
					begin
						state <= ST_SKIP;
						r     <= '0;
					end
				end
				ST_SKIP:
				begin
					c <= '0;
					if (in_row)
						state <= ST_LINE;
					else if (row_last)
						state <= ST_GAP;
					else
						r <= r + 11'h001;
				end
				ST_LINE:
				begin
					// The whole line is clocked even for a narrow window.
					if (room)
					begin
						c <= c + 11'h001;
						if (col_last)
						begin
							c     <= '0;
							state <= row_last ? ST_GAP : ST_SKIP;
							r     <= row_last ? r : r + 11'h001;
						end
					end
				end
				ST_GAP:
				begin
					if (fcnt >= ivl)
					begin
						state <= ST_SKIP;
						r     <= '0;
						fcnt  <= '0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign bar = wx[8:6];
	always_comb
	begin
		case (pat)
			PAT_BLACK: pat_val = LVL_BLACK;
			PAT_WHITE: pat_val = LVL_WHITE;
			PAT_LIGHT: pat_val = LVL_LIGHT;
			PAT_DARK:  pat_val = LVL_DARK;
			PAT_HRAMP: pat_val = wx[7:0];
			PAT_VRAMP: pat_val = wy[7:0];
			PAT_STEPS: pat_val = {bar, 5'h00};
			// Blue-green Bayer: blue on even/even, red on odd/odd, green elsewhere.
			PAT_STRIPES: pat_val = ((wy[0] && wx[0]) ? bar[2] :
				(!wy[0] && !wx[0]) ? bar[0] : bar[1]) ? LVL_WHITE : LVL_BLACK;
			default:   pat_val = LVL_BLACK;
		endcase
	end

	logic i_v, i_sof, i_eol;
	logic [7:0] i_pat;
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || stop_now)
		begin
			sens_rd_o  <= 1'b0;
			sens_row_o <= '0;
			sens_col_o <= '0;
			{i_v, i_sof, i_eol, i_pat} <= '0;
			{q_v, q_sof, q_eol, q_pat} <= '0;
		end
		else
		begin
			sens_rd_o  <= state == ST_LINE && room;
			sens_row_o <= row_addr;
			sens_col_o <= col_addr;
			i_v        <= state == ST_LINE && room && in_col;
			i_sof      <= c == win_hs && r == win_vs;
			i_eol      <= c == 11'(win_hs + win_w - 11'h001);
			i_pat      <= pat_val;
			{q_v, q_sof, q_eol, q_pat} <= {i_v, i_sof, i_eol, i_pat};
		end
	end

	assign push      = q_v && streaming_o;
	// A test image replaces samples in place, so stream timing stays put.
	assign push_data = {q_sof, q_eol, (pat == PAT_OFF) ? sens_data_i : q_pat};

	iwf_fifo #(
		.WIDTH    (FIFO_WIDTH),
		.DEPTH    (FIFO_DEPTH),
		.HEADROOM (FIFO_HEADROOM)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.sys_rst_i   (sys_rst_i),
		.flush_i     (stop_now),
		.in_valid_i  (push),
		.in_data_i   (push_data),
		.in_ready_o  (room),
		.out_valid_o (out_valid_o),
		.out_data_o  (head),
		.out_ready_i (out_ready_i)
	);
	assign {out_sof_o, out_eol_o, out_data_o} = head;

	logic [10:0] line_cnt;
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || !streaming_o)
			line_cnt <= '0;
		else if (push)
			line_cnt <= q_eol ? 11'h000 : line_cnt + 11'h001;
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	start_gate_a: assert property ($rose(streaming_o) |->
		$past(acq_start_i && stream_channel_open_i))
		else $error("Stream started without an open channel.");
	push_open_a: assert property (push |->
		stream_channel_open_i || $past(stream_channel_open_i))
		else $error("Sample queued on a closed channel.");
	geom_lock_a: assert property (streaming_o && !stop_now |=>
		$stable(win_w) && $stable(win_h) && $stable(win_hs) && $stable(win_vs))
		else $error("Window changed during streaming.");
	preset_lock_a: assert property (streaming_o && !stop_now |=>
		$stable(preset) && $stable(bps))
		else $error("Preset or sample size changed during streaming.");
	geom_legal_a: assert property (win_w >= 11'(MIN_W) && win_w[2:0] == 3'h0 &&
		!win_h[0] && win_h >= 11'(MIN_H) && win_hs[2:0] == 3'h0 && !win_vs[0] &&
		{1'b0, win_hs} + {1'b0, win_w} <= 12'(SENSOR_W))
		else $error("Illegal window held.");
	fmt_code_a: assert property (##1
		sample_format_code_o == (COLOUR_MODEL ? CODE_BAYER8 : CODE_MONO8))
		else $error("Wrong sample format code.");
	white_field_a: assert property (push && pat == PAT_WHITE |-> push_data[7:0] == LVL_WHITE)
		else $error("White field sample wrong.");
	pass_through_a: assert property (push && pat == PAT_OFF |->
		$past(sens_rd_o) && push_data[7:0] == sens_data_i)
		else $error("Sensor sample altered with pattern off.");
	skip_fast_a: assert property (state == ST_SKIP && !in_row && !row_last && !stop_now |=>
		r == $past(r) + 11'h001 ##0 state == ST_SKIP)
		else $error("Skipped row took more than one cycle.");
	line_width_a: assert property (push && q_eol |-> line_cnt == win_w - 11'h001)
		else $error("Output line length differs from window width.");

	frame_end_c:  cover property (state == ST_LINE ##1 state == ST_GAP);
	mirror_run_c: cover property (push && mlr && mtb && q_eol);
	pattern_c:    cover property (push && pat == PAT_HRAMP && q_sof);
	reject_c:     cover property (streaming_o && cfg_wr_i && lock_chg);
endmodule : iwf_unit

// file: shared/iwf_pkg.sv
// Purpose: Shared constants and types of the image window and format unit.
// Assumes: One 20 MHz core clock; eight-bit samples only.
// Notes:   Geometry values are in pixels and lines of the full sensor image.
package iwf_pkg;
	localparam int unsigned CLK_MHZ       = 20;
	localparam int unsigned SENSOR_W      = 1920;
	localparam int unsigned SENSOR_H      = 1200;
	localparam int unsigned MIN_W         = 64;
	localparam int unsigned MIN_H         = 64;
	localparam int unsigned W_STEP        = 8;
	localparam int unsigned H_STEP        = 2;
	localparam int unsigned FIFO_DEPTH    = 32;
	localparam int unsigned FIFO_WIDTH    = 10;
	localparam int unsigned FIFO_HEADROOM = 2;
	// Longest frame period at the lowest frame rate of 0.061 Hz.
	localparam int unsigned FRAME_MAX_US  = 16393442;
	localparam int unsigned FRAME_MAX_CYC = FRAME_MAX_US * CLK_MHZ;
	localparam logic [10:0] RST_W         = 11'h780;
	localparam logic [10:0] RST_H         = 11'h4B0;
	localparam logic [10:0] RST_START     = 11'h000;
	localparam logic [31:0] CODE_MONO8    = 32'h01080001;
	localparam logic [31:0] CODE_BAYER8   = 32'h0108000B;
	localparam logic [7:0]  LVL_BLACK     = 8'h00;
	localparam logic [7:0]  LVL_WHITE     = 8'hFF;
	localparam logic [7:0]  LVL_LIGHT     = 8'hAA;
	localparam logic [7:0]  LVL_DARK      = 8'h55;
	localparam logic [1:0]  BPS_EIGHT     = 2'h0;
	localparam logic        ENC_MONO      = 1'b0;
	localparam logic        ENC_BAYER     = 1'b1;

	typedef enum logic [1:0] {
		PRESET_ZERO = 2'h0,
		PRESET_ONE  = 2'h1,
		PRESET_TWO  = 2'h2
	} iwf_preset_t;

	typedef enum logic [3:0] {
		PAT_OFF     = 4'h0,
		PAT_BLACK   = 4'h1,
		PAT_WHITE   = 4'h2,
		PAT_LIGHT   = 4'h3,
		PAT_DARK    = 4'h4,
		PAT_HRAMP   = 4'h5,
		PAT_VRAMP   = 4'h6,
		PAT_STEPS   = 4'h7,
		PAT_STRIPES = 4'h8
	} iwf_pattern_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SKIP = 4'h2,
		ST_LINE = 4'h4,
		ST_GAP  = 4'h8
	} iwf_state_t;
endpackage : iwf_pkg

// file: core/iwf_fifo.sv
// Purpose: Flip-flop FIFO with a registered head between the scan and the output.
// Assumes: Writer pushes at most HEADROOM entries after in_ready_o goes low.
// Notes:   in_ready_o drops HEADROOM entries early to cover the writer's pipeline.
`timescale 1ns/10ps
module iwf_fifo #(
	parameter int unsigned WIDTH    = 10,
	parameter int unsigned DEPTH    = 32,
	parameter int unsigned HEADROOM = 2
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign push = in_valid_i && (count < (AW+1)'(DEPTH)) && !flush_i;
	assign pop  = (count != '0) && (!out_valid_o || out_ready_i) && !flush_i;

	always_ff @(posedge core_clk_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || flush_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
			count  <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || flush_i)
		begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end
		else if (pop)
		begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem[rd_ptr];
		end
		else if (out_ready_i)
			out_valid_o <= 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i || flush_i)
			in_ready_o <= 1'b0;
		else
			in_ready_o <= (count + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH - HEADROOM);
	end
endmodule : iwf_fifo

// file: test/iwf_far_side.sv
// Purpose: Sensor array and stream sink that stand beyond the unit.
// Assumes: The sensor answers in the cycle after a read request.
// Notes:   The sink refuses one beat in four while stall_i is high.
`timescale 1ns/10ps
module iwf_far_side (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        sens_rd_i,
	input  wire logic [10:0] sens_row_i,
	input  wire logic [10:0] sens_col_i,
	input  wire logic        stall_i,
	output logic      [7:0]  sens_data_o,
	output logic             out_ready_o
);
	logic [1:0] beat_cnt;

	// Between reads the bus keeps changing, so a late or stale sample cannot pass.
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			sens_data_o <= 8'h5A;
		else if (sens_rd_i)
			sens_data_o <= 8'(sens_col_i + sens_row_i * 11'h011);
		else
			sens_data_o <= ~sens_data_o;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			beat_cnt <= 2'h0;
		else
			beat_cnt <= beat_cnt + 2'h1;
	end

	always_ff @(posedge core_clk_i)
	begin
		out_ready_o <= !(stall_i && beat_cnt == 2'h3);
	end
endmodule : iwf_far_side

// file: test/tb.sv
// Purpose: Self-checking bench for the window and format unit.
// Assumes: Mono model; short frame limit; one line of each frame is checked.
// Notes:   Sensor sample value is col + 17 * row, truncated to eight bits.
`timescale 1ns/10ps
module tb import iwf_pkg::*; ;
	logic        core_clk, sys_rst, open_ch, acq_start, acq_stop, cfg_wr;
	logic [1:0]  preset_sel, bps_sel, fmt_preset;
	logic [10:0] win_w, win_h, roi_h, roi_v, sens_row, sens_col;
	logic        mir_lr, mir_tb, enc_sel, byte_sel, byte_ord, stall;
	logic [3:0]  pat_sel;
	logic [7:0]  sens_data, out_data;
	logic        out_ready, sens_rd, out_valid, out_sof, out_eol, streaming, cfg_rej;
	logic [31:0] fmt_code;
	int          mismatches, checked, first, i;
	localparam logic [7:0] LVLS [4] = '{LVL_BLACK, LVL_WHITE, LVL_LIGHT, LVL_DARK};

	iwf_unit #(.COLOUR_MODEL(1'b0), .MAX_FRAME_CYC(4000)) u_dut (
		.core_clk_i(core_clk), .sys_rst_i(sys_rst), .stream_channel_open_i(open_ch),
		.acq_start_i(acq_start), .acq_stop_i(acq_stop), .cfg_wr_i(cfg_wr),
		.format_preset_select_i(preset_sel), .width_i(win_w), .height_i(win_h),
		.roi_horizontal_start_i(roi_h), .roi_vertical_start_i(roi_v),
		.mirror_left_right_i(mir_lr), .mirror_top_bottom_i(mir_tb),
		.sample_encoding_select_i(enc_sel), .bits_per_sample_select_i(bps_sel),
		.sample_byte_order_i(byte_sel), .synthetic_image_select_i(pat_sel),
		.frame_interval_i(32'h00000000), .sens_data_i(sens_data), .out_ready_i(out_ready),
		.sens_rd_o(sens_rd), .sens_row_o(sens_row), .sens_col_o(sens_col),
		.out_valid_o(out_valid), .out_data_o(out_data), .out_sof_o(out_sof),
		.out_eol_o(out_eol), .streaming_o(streaming), .cfg_reject_o(cfg_rej),
		.sample_byte_order_o(byte_ord), .format_preset_o(fmt_preset),
		.sample_format_code_o(fmt_code));

	iwf_far_side u_far (
		.core_clk_i(core_clk), .sys_rst_i(sys_rst), .sens_rd_i(sens_rd),
		.sens_row_i(sens_row), .sens_col_i(sens_col), .stall_i(stall),
		.sens_data_o(sens_data), .out_ready_o(out_ready));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic results;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic tick;
		@(posedge core_clk);
		#2;
	endtask : tick

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic wcfg(input logic [10:0] w, h, hs, vs, input logic [1:0] pre,
			input logic [3:0] pat, input logic rej);
		win_w = w;
		win_h = h;
		roi_h = hs;
		roi_v = vs;
		preset_sel = pre;
		pat_sel = pat;
		cfg_wr = 1'b1;
		tick();
		chk(cfg_rej, rej, "reject");
		cfg_wr = 1'b0;
		tick();
		chk(cfg_rej, 0, "reject pulse");
	endtask : wcfg

	// Streams one line of a 64 wide window, then stops by command or by closing.
	task automatic run_line(input logic [10:0] row, input logic lvl_on, input logic [7:0] lvl,
			input logic close, input logic probe);
		int n;
		int k;
		logic [10:0] col;
		logic [7:0] exp;
		n = 0;
		first = -1;
		acq_start = 1'b1;
		tick();
		acq_start = 1'b0;
		chk(streaming, 1, "start");
		for (k = 0; k < 3000 && n < 64; k++)
		begin
			tick();
			if (out_valid === 1'b1 && out_ready === 1'b1)
			begin
				col = mir_lr ? roi_h + 11'h03F - 11'(n) : roi_h + 11'(n);
				exp = lvl_on ? lvl : 8'(col + row * 11'h011);
				if (pat_sel == PAT_HRAMP)
					exp = 8'(n);
				if (n == 0)
					first = k;
				chk(out_data, exp, "pixel");
				chk(out_sof, n == 0, "frame start");
				chk(out_eol, n == 63, "line end");
				n++;
			end
		end
		chk(n, 64, "beats");
		if (probe)
		begin
			wcfg(11'h048, 11'h040, roi_h, roi_v, PRESET_ZERO, pat_sel, 1'b1);
			wcfg(11'h040, 11'h040, roi_h, roi_v, PRESET_ONE, pat_sel, 1'b1);
			wcfg(11'h040, 11'h040, roi_h + 11'h008, roi_v, PRESET_ZERO, pat_sel, 1'b1);
		end
		if (close)
			open_ch = 1'b0;
		else
			acq_stop = 1'b1;
		tick();
		acq_stop = 1'b0;
		chk(streaming, 0, "stop");
		chk(out_valid, 0, "flush");
		open_ch = 1'b1;
	endtask : run_line

	initial
	begin
		{open_ch, acq_start, acq_stop, cfg_wr, mir_lr, mir_tb, enc_sel, byte_sel} = 8'h00;
		{preset_sel, bps_sel, pat_sel} = 8'h00;
		{win_w, win_h, roi_h, roi_v} = {11'h780, 11'h4B0, 22'h000000};
		stall = 1'b1;
		sys_rst = 1'b1;
		mismatches = 0;
		checked = 0;
		repeat (10) @(posedge core_clk);
		#2;
		sys_rst = 1'b0;
		chk(fmt_code, CODE_MONO8, "code");
		chk(fmt_preset, PRESET_ZERO, "preset");
		chk(streaming, 0, "idle");
		wcfg(11'h041, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h038, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h03F, 11'h000, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h040, 11'h004, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h040, 11'h000, 11'h001, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h048, 11'h040, 11'h740, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h044, 11'h000, 11'h46E, PRESET_ZERO, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h042, 11'h740, 11'h46E, PRESET_ZERO, PAT_OFF, 1'b0);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, 2'h3, PAT_OFF, 1'b1);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_TWO, PAT_OFF, 1'b0);
		chk(fmt_preset, PRESET_TWO, "preset two");
		byte_sel = 1'b1;
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ONE, PAT_OFF, 1'b0);
		chk(fmt_preset, PRESET_ONE, "preset one");
		chk(byte_ord, 1, "byte order");
		enc_sel = 1'b1;
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		enc_sel = 1'b0;
		bps_sel = 2'h1;
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_OFF, 1'b1);
		bps_sel = BPS_EIGHT;
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, 4'h9, 1'b1);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_STRIPES, 1'b1);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_STEPS, 1'b0);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_HRAMP, 1'b0);
		wcfg(11'h040, 11'h040, 11'h000, 11'h000, PRESET_ZERO, PAT_VRAMP, 1'b0);
		acq_start = 1'b1;
		tick();
		acq_start = 1'b0;
		tick();
		chk(streaming, 0, "closed start");
		open_ch = 1'b1;
		wcfg(11'h040, 11'h040, 11'h008, 11'h002, PRESET_ZERO, PAT_OFF, 1'b0);
		run_line(11'h002, 1'b0, 8'h00, 1'b0, 1'b1);
		mir_lr = 1'b1;
		wcfg(11'h040, 11'h040, 11'h008, 11'h002, PRESET_ZERO, PAT_OFF, 1'b0);
		run_line(11'h002, 1'b0, 8'h00, 1'b0, 1'b0);
		mir_tb = 1'b1;
		wcfg(11'h040, 11'h040, 11'h008, 11'h002, PRESET_ZERO, PAT_OFF, 1'b0);
		run_line(11'h041, 1'b0, 8'h00, 1'b1, 1'b0);
		mir_lr = 1'b0;
		mir_tb = 1'b0;
		for (i = 0; i < 4; i++)
		begin
			stall = i[0];
			wcfg(11'h040, 11'h040, 11'h008, 11'h002, PRESET_ZERO, 4'(PAT_BLACK + i), 1'b0);
			run_line(11'h002, 1'b1, LVLS[i], 1'b0, 1'b0);
		end
		wcfg(11'h040, 11'h040, 11'h008, 11'h002, PRESET_ZERO, PAT_HRAMP, 1'b0);
		run_line(11'h002, 1'b0, 8'h00, 1'b0, 1'b0);
		wcfg(11'h040, 11'h040, 11'h008, 11'h190, PRESET_ZERO, PAT_OFF, 1'b0);
		run_line(11'h190, 1'b0, 8'h00, 1'b0, 1'b0);
		chk(first >= 0 && first < 600, 1, "skip speed");
		results();
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		results();
	end
endmodule : tb
